//--- hdl/idsr_top.sv
/*
  Input deserializer: samples a serial pin on a serial clock and, in double edge, its complement,
  assembles 2-, 4- or 8-bit words and hands them out directly or through an
  eight-entry FIFO, with configuration and status over APB.
  Assumes every link pin is asynchronous to pclk and slow enough to be
  oversampled: each pin level lasts at least three pclk cycles.
*/
// The placing of the registers and the APB register port are this design's own decisions.
// Operation
// - Ratios 2/4 single edge, 4/8 double edge.
// - Single edge fills even bits only; each odd bit here repeats the even bit below.
// - Double edge fills all eight or low four.
// - Earliest serial bit lands on bit zero.
// - Optional eight-entry FIFO carries words across.
// - FIFO latency follows read clock phase.
// - Output word registered, read-clock timed with FIFO.
// - Serial data sampled on both serial clocks in double edge, on the serial clock only in single edge.
// - Reset asserts and releases asynchronously.
// - One FIFO entry per enabled read edge.
// - Empty flag set exactly when nothing unread.
// - Word width selects four or eight.
// - FIFO setting routes or bypasses the FIFO.
`timescale 1ns/100ps
module idsr_top #(
  parameter int WORD_BITS = idsr_pkg::IDSR_WORD_BITS,
  parameter int FIFO_DEPTH = idsr_pkg::IDSR_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_data,
  input wire logic serial_clock,
  input wire logic serial_clock_b,
  input wire logic divided_word_clock,
  input wire logic fifo_rd_clk,
  input wire logic fifo_rd_en,
  output logic [WORD_BITS-1:0] par_word,
  output logic fifo_empty,
  output logic reserved_divided_clock_out
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] PTR_ONE = {{(PW-1){1'b0}}, 1'b1};
  localparam logic [PW-1:0] DEPTH_P = PW'(FIFO_DEPTH);

  // True when the word address selects the given register offset.
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a[7:2] == ofs[7:2]);
  endfunction

  // Next shift value for one captured bit; single edge writes each bit twice so
  // that only even positions carry distinct bits, and width 4 keeps the top zero.
  function automatic logic [7:0] next_shift(input logic [7:0] s, input logic d,
                                            input logic ddr, input logic w8);
    logic [7:0] r;
    r = s;
    if (w8 && ddr) begin
      r = {d, s[7:1]};
    end else if (w8) begin
      r = {d, d, s[7:2]};
    end else if (ddr) begin
      r = {4'h0, d, s[3:1]};
    end else begin
      // Two bit positions per serial bit keep the valid bits on even places.
      r = {4'h0, d, d, s[3:2]};
    end
    next_shift = r;
  endfunction

  // Control register and the decoded fields.
  idsr_pkg::idsr_ctrl_s ctrl_q; // Software configuration.
  logic ovf_q;                  // Sticky FIFO overflow flag.

  // Pin synchronisers; stage one feeds stage two only, stages two and three give edges.
  idsr_pkg::idsr_link_s sync1_q;
  idsr_pkg::idsr_link_s sync2_q;
  idsr_pkg::idsr_link_s sync3_q;

  // Capture path.
  logic [7:0] shift_q;       // Most recent serial bits; not cleared at a word boundary.
  logic [7:0] word_q;        // Last word taken at a divided clock edge.
  logic [WORD_BITS-1:0] par_word_q;
  logic reserved_div_q;

  // FIFO storage and pointers, one extra pointer bit tells full from empty.
  logic [WORD_BITS-1:0] fifo_mem_q [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic fifo_empty_q;

  // APB answer registers.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Edge detection on the synchronised clock pins.
  wire ser_rise = sync2_q.serial_clock & ~sync3_q.serial_clock;
  wire ser_fall = ~sync2_q.serial_clock & sync3_q.serial_clock;
  wire comp_rise = sync2_q.serial_clock_b & ~sync3_q.serial_clock_b;
  wire comp_fall = ~sync2_q.serial_clock_b & sync3_q.serial_clock_b;
  wire div_rise = sync2_q.divided_word_clock & ~sync3_q.divided_word_clock;
  wire rd_rise = sync2_q.fifo_rd_clk & ~sync3_q.fifo_rd_clk;

  // Local inversion picks which pin level change counts as the active edge.
  wire ser_edge = ctrl_q.serial_clock_invert ? ser_fall : ser_rise;
  wire comp_edge = ctrl_q.complement_clock_invert ? comp_fall : comp_rise;
  // Single edge capture ignores the complement pin entirely.
  wire sample_en = ser_edge | (ctrl_q.ddr_mode & comp_edge);

  // The word as it stands at a boundary; width 4 clears the top nibble.
  wire [7:0] cap_word = ctrl_q.width8 ? shift_q : {4'h0, shift_q[3:0]};

  // APB decode.
  wire apb_access = psel & penable;
  wire apb_done = apb_access & pready_q;
  wire hit_ctrl = addr_hit(paddr, idsr_pkg::IDSR_CTRL_OFS);
  wire hit_status = addr_hit(paddr, idsr_pkg::IDSR_STATUS_OFS);
  wire hit_word = addr_hit(paddr, idsr_pkg::IDSR_WORD_OFS);
  wire hit_any = hit_ctrl | hit_status | hit_word;
  wire ctrl_wr = apb_done & pwrite & hit_ctrl;
  wire ovf_clr = apb_done & pwrite & hit_status & pwdata[idsr_pkg::IDSR_STAT_OVF_BIT];

  // FIFO occupancy and the two transfer strobes.
  wire [PW-1:0] fifo_level = wr_ptr_q - rd_ptr_q;
  wire fifo_full = (fifo_level == DEPTH_P);
  wire fifo_wr = div_rise & ctrl_q.fifo_enable & ~fifo_full;
  wire fifo_ovf = div_rise & ctrl_q.fifo_enable & fifo_full;
  // A read needs the enable level seen together with the read clock edge.
  wire fifo_rd = rd_rise & sync2_q.fifo_rd_en & ~fifo_empty_q;
  wire [PW-1:0] wr_ptr_d = fifo_wr ? wr_ptr_q + PTR_ONE : wr_ptr_q;
  wire [PW-1:0] rd_ptr_d = fifo_rd ? rd_ptr_q + PTR_ONE : rd_ptr_q;

  // Read data multiplexer.
  wire [31:0] status_word = {{(32 - idsr_pkg::IDSR_STAT_LEVEL_LSB - PW){1'b0}}, fifo_level,
                             2'h0, ovf_q, fifo_empty_q};
  wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
                       hit_status ? status_word :
                       hit_word ? {24'h0, word_q} : 32'h0;

  // Three-stage pin capture; only stages two and three are read by logic.
  // Stage one may go metastable, so nothing but stage two ever looks at it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {serial_data, serial_clock, serial_clock_b, divided_word_clock,
                  fifo_rd_clk, fifo_rd_en};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Configuration register; a write flushes the capture path below.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= idsr_pkg::IDSR_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[idsr_pkg::IDSR_CTRL_BITS-1:0];
    end
  end

  // Overflow is sticky and a new overflow beats a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
    end else if (fifo_ovf) begin
      ovf_q <= 1'b1;
    end else if (ovf_clr) begin
      ovf_q <= 1'b0;
    end
  end

  // Shift register; new bits enter at the top so the oldest ends at bit zero.
  // Mixing old bits into a new mode would give a garbled word, hence the flush.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 8'h00;
    end else if (ctrl_wr) begin
      shift_q <= 8'h00;
    end else if (sample_en) begin
      shift_q <= next_shift(shift_q, sync2_q.serial_data, ctrl_q.ddr_mode,
                            ctrl_q.width8);
    end
  end

  // Word boundary at each rising divided clock edge, kept for software to read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 8'h00;
    end else if (ctrl_wr) begin
      word_q <= 8'h00;
    end else if (div_rise) begin
      word_q <= cap_word;
    end
  end

  // FIFO storage; no reset is needed since only written entries are read.
  always_ff @(posedge pclk) begin
    if (fifo_wr) begin
      fifo_mem_q[wr_ptr_q[AW-1:0]] <= cap_word[WORD_BITS-1:0];
    end
  end

  // FIFO pointers and the registered empty flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fifo_empty_q <= 1'b1;
    end else if (ctrl_wr) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fifo_empty_q <= 1'b1;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      fifo_empty_q <= (wr_ptr_d == rd_ptr_d);
    end
  end

  // Output word: read-clock timed through the FIFO, divided-clock timed without.
  // The FIFO latency thus depends on where the write lands against the read edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_word_q <= '0;
    end else if (ctrl_wr) begin
      par_word_q <= '0;
    end else if (ctrl_q.fifo_enable) begin
      if (fifo_rd) begin
        par_word_q <= fifo_mem_q[rd_ptr_q[AW-1:0]];
      end
    end else if (div_rise) begin
      par_word_q <= cap_word[WORD_BITS-1:0];
    end
  end

  // Copy of the divided clock as seen after synchronisation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reserved_div_q <= 1'b0;
    end else begin
      reserved_div_q <= sync3_q.divided_word_clock;
    end
  end

  // APB slave with one wait state; unmapped addresses answer with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_access & ~pready_q;
      pslverr_q <= apb_access & ~pready_q & ~hit_any;
      if (apb_access && !pready_q && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign par_word = par_word_q;
  assign fifo_empty = fifo_empty_q;
  assign reserved_divided_clock_out = reserved_div_q;

  // A write into an empty FIFO, then the flag drops.
  sequence s_lone_write;
    fifo_empty_q && fifo_wr;
  endsequence

  // An enabled read clock edge with a word waiting.
  sequence s_read_edge;
    fifo_rd && ctrl_q.fifo_enable && !ctrl_wr;
  endsequence

  // A bypassed boundary with no configuration write.
  sequence s_bypass_edge;
    div_rise && !ctrl_q.fifo_enable && !ctrl_wr;
  endsequence

  chk_sdr_even_bits: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.ddr_mode |-> (shift_q[1] == shift_q[0]) && (shift_q[3] == shift_q[2]) &&
      (shift_q[5] == shift_q[4]) && (shift_q[7] == shift_q[6]))
    else $error("single edge word has distinct odd bits");

  chk_width4_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.width8 && !ctrl_q.fifo_enable) |=> (par_word_q[7:4] == 4'h0) || $past(ctrl_wr))
    else $error("width 4 word drives the upper nibble");

  chk_oldest_bit_low: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_en && ctrl_q.ddr_mode && ctrl_q.width8 && !ctrl_wr) |=>
      (shift_q[6:0] == $past(shift_q[7:1])) && (shift_q[7] == $past(sync2_q.serial_data)))
    else $error("serial bits do not move toward bit zero");

  chk_sdr_ignore_comp: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.ddr_mode && comp_edge && !ser_edge && !ctrl_wr) |=> $stable(shift_q))
    else $error("single edge capture used the complement clock");

  chk_bypass_update: assert property (@(posedge pclk) disable iff (!presetn)
    s_bypass_edge |=> par_word_q == $past(cap_word[WORD_BITS-1:0]))
    else $error("bypassed word missed the divided clock edge");

  chk_bypass_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.fifo_enable && !div_rise && !ctrl_wr) |=> $stable(par_word_q))
    else $error("bypassed word changed between boundaries");

  chk_fifo_one_read: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_edge |=> (rd_ptr_q == $past(rd_ptr_q) + PTR_ONE) ##1 $stable(rd_ptr_q))
    else $error("read edge did not take exactly one entry");

  // A read right behind the write may legally empty the FIFO again.
  chk_empty_drops: assert property (@(posedge pclk) disable iff (!presetn)
    (s_lone_write and !ctrl_wr) |=> !fifo_empty_q ##1
      (!fifo_empty_q || $past(fifo_rd) || $past(ctrl_wr)))
    else $error("empty flag stayed high with a word stored");

  chk_fifo_depth: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_level <= DEPTH_P)
    else $error("FIFO holds more than its depth");

  chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_access && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("APB answer not given after one wait state");

endmodule

//--- inc/idsr_pkg.sv
/*
  Shared constants and types for the input deserializer with its word FIFO.
  Assumes a 32-bit APB register bus and a single system clock for all logic.
*/
package idsr_pkg;

  // Byte addresses of the three registers on the APB slave.
  localparam logic [7:0] IDSR_CTRL_OFS = 8'h00;
  localparam logic [7:0] IDSR_STATUS_OFS = 8'h04;
  localparam logic [7:0] IDSR_WORD_OFS = 8'h08;

  // Field positions in the control register.
  localparam int IDSR_CTRL_DDR_BIT = 0;
  localparam int IDSR_CTRL_WIDTH8_BIT = 1;
  localparam int IDSR_CTRL_FIFO_BIT = 2;
  localparam int IDSR_CTRL_SINV_BIT = 3;
  localparam int IDSR_CTRL_CINV_BIT = 4;
  localparam int IDSR_CTRL_BITS = 5;

  // Field positions in the status register.
  localparam int IDSR_STAT_EMPTY_BIT = 0;
  localparam int IDSR_STAT_OVF_BIT = 1;
  localparam int IDSR_STAT_LEVEL_LSB = 4;

  // Control value after reset: double-edge capture, width 8, FIFO bypassed.
  localparam logic [4:0] IDSR_CTRL_RESET = 5'h03;

  // Number of flip-flops that each pin passes before any logic reads it.
  localparam int IDSR_SYNC_STAGES = 2;

  // Documented word width and FIFO depth.
  localparam int IDSR_WORD_BITS = 8;
  localparam int IDSR_FIFO_DEPTH = 8;

  // Configuration held in the control register, lowest field last.
  typedef struct packed {
    logic complement_clock_invert; // Capture on the falling level of the complement pin.
    logic serial_clock_invert;     // Capture on the falling level of the serial clock.
    logic fifo_enable;             // Route words through the FIFO.
    logic width8;                  // Word width 8 when set, 4 when clear.
    logic ddr_mode;                // Capture on both clocks when set.
  } idsr_ctrl_s;

  // Pins that arrive from outside the system clock domain.
  typedef struct packed {
    logic serial_data;
    logic serial_clock;
    logic serial_clock_b;
    logic divided_word_clock;
    logic fifo_rd_clk;
    logic fifo_rd_en;
  } idsr_link_s;

endpackage

//--- tb/idsr_serial_src.sv
/*
  Serial source model: drives the data pin, the serial clock pair and the divided clock.
  Assumes one task call at a time; between words the clocks stand still.
*/
`timescale 1ns/100ps
module idsr_serial_src (
  output logic serial_data,
  output logic serial_clock,
  output logic serial_clock_b,
  output logic divided_word_clock,
  input wire logic share_buf
);
  // Idle levels; the complement pin starts as the inverse of the serial clock.
  initial begin
    serial_data = 1'b0;
    serial_clock = 1'b0;
    serial_clock_b = 1'b1;
    divided_word_clock = 1'b0;
  end

  // Sets the pair; with a shared buffer both pins carry the same level.
  function automatic void set_clk(input logic lv);
    serial_clock = lv;
    serial_clock_b = share_buf ? lv : ~lv;
  endfunction

  // Sends n bits, earliest first, then one divided clock pulse to end the word.
  task automatic send_word(input logic [7:0] w, input int n, input logic ddr);
    logic ph;
    ph = 1'b0;
    // The offset keeps link edges away from the pclk edges.
    #7;
    for (int i = 0; i < n; i++) begin
      serial_data = w[i];
      #40;
      if (ddr) begin
        ph = ~ph;
        set_clk(ph);
        #40;
      end else begin
        set_clk(1'b1);
        #80;
        set_clk(1'b0);
        #40;
      end
    end
    // The data hold has run out, so show the inverse rather than a stale copy.
    serial_data = ~serial_data;
    #40;
    divided_word_clock = 1'b1;
    #80;
    divided_word_clock = 1'b0;
  endtask
endmodule

//--- tb/testbench.sv
/*
  Self-checking bench for the deserializer: registers, every capture mode and the FIFO.
  Assumes the serial source model owns the link pins and pclk runs at 50 MHz.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr, par_word;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, fifo_empty, fifo_rd_clk, fifo_rd_en, share_buf;
  logic serial_data, serial_clock, serial_clock_b, divided_word_clock;
  logic div_copy; // Delayed copy of the divided clock from the block.
  int n_mismatch = 0; // Failed comparisons.
  int n_checks = 0; // All comparisons.

  idsr_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_data(serial_data), .serial_clock(serial_clock),
    .serial_clock_b(serial_clock_b), .divided_word_clock(divided_word_clock),
    .fifo_rd_clk(fifo_rd_clk), .fifo_rd_en(fifo_rd_en), .par_word(par_word),
    .fifo_empty(fifo_empty), .reserved_divided_clock_out(div_copy));
  idsr_serial_src u_src (.serial_data(serial_data), .serial_clock(serial_clock),
    .serial_clock_b(serial_clock_b), .divided_word_clock(divided_word_clock),
    .share_buf(share_buf));

  // Clock of 20 ns.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge pclk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    // Levels read just after an edge are those the slave showed before it.
    // A slave that never answers is caught by the watchdog.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected word: earliest bit lowest; single-edge bits land on even positions only.
  function automatic logic [7:0] exp_word(input logic [7:0] w, input int n, input logic ddr);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < n; i++) begin
      if (ddr) e[i] = w[i];
      else e[2*i] = w[i];
    end
    return e;
  endfunction

  // One read-clock period with the enable taken from the empty flag.
  task automatic fifo_pop();
    @(posedge pclk);
    fifo_rd_en <= ~fifo_empty;
    repeat (4) @(posedge pclk);
    fifo_rd_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    fifo_rd_clk <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // Reset values, a write to the read-only word and an unmapped read.
  task automatic t_regs();
    `CHK("fifo_empty", 1'b1, fifo_empty)
    apb(idsr_pkg::IDSR_CTRL_OFS, 1'b0, 32'h0);
    `CHK("ctrl", 32'h00000003, rd)
    apb(idsr_pkg::IDSR_WORD_OFS, 1'b1, 32'h000000FF);
    apb(idsr_pkg::IDSR_WORD_OFS, 1'b0, 32'h0);
    `CHK("word_reg", 32'h00000000, rd)
    apb(8'h0C, 1'b0, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
  endtask

  // Every capture mode, two words each so that each word must replace the last.
  task automatic t_modes();
    logic [7:0] cfg [6] = '{8'h03, 8'h13, 8'h01, 8'h02, 8'h0A, 8'h00};
    logic [7:0] w, m;
    int n;
    for (int k = 0; k < 6; k++) begin
      share_buf = cfg[k][4];
      u_src.set_clk(1'b0);
      apb(idsr_pkg::IDSR_CTRL_OFS, 1'b1, {24'h0, cfg[k]});
      n = cfg[k][0] ? (cfg[k][1] ? 8 : 4) : (cfg[k][1] ? 4 : 2);
      m = cfg[k][0] ? 8'hFF : 8'h55;
      for (int j = 0; j < 2; j++) begin
        w = j ? 8'h5A : 8'hA5;
        u_src.send_word(w, n, cfg[k][0]);
        repeat (3) @(posedge pclk);
        `CHK("par_word", exp_word(w, n, cfg[k][0]), par_word & m)
        // The copy lags the pin by four pclk, so it is still high here.
        `CHK("div_copy", 1'b1, div_copy)
      end
      apb(idsr_pkg::IDSR_WORD_OFS, 1'b0, 32'h0);
      `CHK("word_reg", {24'h0, exp_word(w, n, cfg[k][0])}, rd & {24'h0, m})
    end
  endtask

  // Nine words into the eight-entry FIFO, then drained in order.
  task automatic t_fifo();
    apb(idsr_pkg::IDSR_CTRL_OFS, 1'b1, 32'h00000007);
    for (int i = 0; i < 9; i++) u_src.send_word(8'(8'h10 + i), 8, 1'b1);
    repeat (3) @(posedge pclk);
    `CHK("fifo_empty", 1'b0, fifo_empty)
    `CHK("par_word", 8'h00, par_word)
    apb(idsr_pkg::IDSR_STATUS_OFS, 1'b0, 32'h0);
    `CHK("status", 32'h00000082, rd)
    apb(idsr_pkg::IDSR_STATUS_OFS, 1'b1, 32'h00000002);
    apb(idsr_pkg::IDSR_STATUS_OFS, 1'b0, 32'h0);
    `CHK("status", 32'h00000080, rd)
    for (int i = 0; i < 8; i++) begin
      fifo_pop();
      `CHK("fifo_word", 8'(8'h10 + i), par_word)
    end
    `CHK("fifo_empty", 1'b1, fifo_empty)
    // A read edge on an empty FIFO leaves the word alone.
    fifo_pop();
    `CHK("par_word", 8'h17, par_word)
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 20 us.
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end

  // Main sequence; unused FIFO controls stay low until the FIFO is in use.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    share_buf = 1'b0;
    fifo_rd_clk = 1'b0;
    fifo_rd_en = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_fifo();
    end_of_test();
  end
endmodule
